// ==== test/mixer_ctl_tb.sv ====
// Self-checking bench for the mixer control bank, driving it as an AXI4-Lite master.
// Assumes the sample source model and the package are compiled first.
`timescale 1ns/100ps
module mixer_ctl_tb
  import mixer_ctl_pkg::*;
;
  // ==========================================================================
  // Signals and bookkeeping.
  // ==========================================================================
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, run, zero, sample_valid;
  logic [7:0] awaddr, araddr, conv_att, ser_att, hpf_hz;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [23:0] left_s, right_s;
  logic conv_m, ser_m, mix_a, main_m, conv_mo, ser_mo, bias, lon, ron, lz, rz;
  logic [2:0] deemph;
  logic [3:0] wstrb;   // Byte enables offered with each write.
  logic [4:0] lgain, rgain;
  logic [1:0] wq[$];   // Expected write responses, oldest first.
  logic [33:0] rq[$];  // Expected {rresp, rdata}, oldest first.
  int bad_count, tests_run, cyc;
  logic [7:0] vtab[9] = '{8'h00, 8'h04, 8'h05, 8'hB3, 8'hC0, 8'hC4, 8'hC8, 8'hCB, 8'hCC};
  logic [7:0] htab[4] = '{8'h00, 8'h03, 8'h64, 8'hC8};
  int wtab[4] = '{3200, 4800, 9600, 19600};

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  sample_src src (.aclk(aclk), .run(run), .zero(zero), .sample_valid(sample_valid),
    .left_sample(left_s), .right_sample(right_s));

  mixer_ctl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sample_valid(sample_valid), .left_sample(left_s), .right_sample(right_s),
    .converter_atten_qdb(conv_att), .converter_blend_mute(conv_m),
    .serial_atten_qdb(ser_att), .serial_blend_mute(ser_m), .mix_active(mix_a),
    .main_mute_out(main_m), .converter_mute_out(conv_mo), .serial_mute_out(ser_mo),
    .deemph_sel(deemph), .hpf_corner_hz(hpf_hz), .bias_on(bias),
    .left_converter_on(lon), .right_converter_on(ron), .left_gain_db(lgain),
    .right_gain_db(rgain), .left_zero_flag(lz), .right_zero_flag(rz));

  // ==========================================================================
  // Checking helpers.
  // ==========================================================================
  task automatic stop_test;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Expected {full mute, attenuation in quarter dB} of a blend gain code.
  function automatic logic [8:0] exp_vol(input logic [7:0] c);
    if (c >= 8'hCC) return 9'h100;
    if (c >= 8'hC8) return 9'h0F0;
    if (c >= 8'hC4) return 9'h0D8;
    if (c >= 8'hC0) return 9'h0CC;
    if (c >= 8'hBC) return 9'h0C0;
    if (c >= 8'hB8) return 9'h0B8;
    return (c <= 8'h04) ? 9'h000 : 9'({1'b0, c - 8'h04});
  endfunction : exp_vol

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  // Monitor: each answer on the bus retires the oldest note; also the hang limit.
  always @(posedge aclk)
  begin
    cyc++;
    if (bvalid === 1'b1 && bready && wq.size() > 0) chk(34'(bresp), 34'(wq.pop_front()));
    if (rvalid === 1'b1 && rready && rq.size() > 0) chk({rresp, rdata}, rq.pop_front());
    if (cyc == 60000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // Bus and sample tasks.
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_d, w_d;
    wq.push_back(er);
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_d = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_d = 1'b1; wvalid <= 1'b0; end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    // One idle edge, so a following call never drives bready twice in a step.
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    rq.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    // One idle edge, so a following call never drives rready twice in a step.
    @(posedge aclk);
  endtask : rd

  // Feeds n sample pairs, then lets one idle edge pass so the flags have landed.
  task automatic burst(input int n, input logic z);
    zero <= z;
    run <= 1'b1;
    repeat (n) @(posedge aclk);
    run <= 1'b0;
    @(posedge aclk);
  endtask : burst

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial
  begin
    logic [7:0] c;
    logic [31:0] w;
    logic [3:0] lg_e, rg_e;
    logic [2:0] de_e;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, run, zero} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {lg_e, rg_e, de_e} = '0;
    c = 8'h18;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CONV_VOL_OFS, {RESP_OKAY, 32'h0000_0000});
    rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    // Blend gains: table codes at the decode boundaries, then LFSR codes.
    for (int i = 0; i < 24; i++)
    begin
      c = (i < 9) ? vtab[i] : lfsr(c);
      wr(CONV_VOL_OFS, {24'h0, c}, RESP_OKAY);
      wr(SER_VOL_OFS, {24'h0, ~c}, RESP_OKAY);
      chk(34'({conv_m, conv_att}), 34'(exp_vol(c)));
      chk(34'({ser_m, ser_att}), 34'(exp_vol(~c)));
    end
    // Every mute and mixer combination, de-emphasis and filter codes taken from the same bits; path mutes act in mixer mode only.
    for (int i = 0; i < 16; i++)
    begin
      w = {23'h0, i[3], i[2], i[1], i[0], i[1:0], i[2:0]};
      wr(MIX_CTL_OFS, w, RESP_OKAY);
      if (i[2:0] <= 3'h4) de_e = i[2:0];
      chk(34'(deemph), 34'(de_e));
      chk(34'(hpf_hz), 34'(htab[i % 4]));
      chk(34'({mix_a, main_m, conv_mo, ser_mo}), 34'({i[0], i[1], i[2] & i[0], i[3] & i[0]}));
      rd(STATUS_OFS, {RESP_OKAY, 29'h0, i[1], i[2] & i[0], i[3] & i[0]});
      rd(MIX_CTL_OFS, {RESP_OKAY, w});
    end
    wr(STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    rd(STATUS_OFS, {RESP_OKAY, 32'h0000_0007});
    // Power and input gains, reserved gain codes included.
    for (int i = 0; i < 16; i++)
    begin
      wr(ADC_CTL_OFS, {21'h0, i[2], i[1], i[0], i[3:0], 4'(15 - i)}, RESP_OKAY);
      if (i[3:0] <= GAIN_MAX_CODE) lg_e = i[3:0];
      if (4'(15 - i) <= GAIN_MAX_CODE) rg_e = 4'(15 - i);
      chk(34'({lgain, rgain}), 34'({5'(lg_e * 3), 5'(rg_e * 3)}));
      chk(34'({bias, lon, ron}), 34'({i[2], i[2] & i[0], i[2] & i[1]}));
    end
    // Byte lane 1 only: power bits clear, the gain byte and the gains in use stay.
    wstrb <= 4'h2;
    wr(ADC_CTL_OFS, 32'h0000_0077, RESP_OKAY);
    wstrb <= 4'hF;
    chk(34'({bias, lon, ron}), 34'(3'b000));
    chk(34'({lgain, rgain}), 34'({5'(lg_e * 3), 5'(rg_e * 3)}));
    rd(ADC_CTL_OFS, {RESP_OKAY, 32'h0000_00F0});
    // Silence windows: one sample short stays clear, the last one sets both flags.
    wr(MIX_CTL_OFS, 32'h0000_0000, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(SILENCE_OFS, 32'(i * 2 + 1), RESP_OKAY);
      burst(1, 1'b0);
      burst(wtab[i] - 1, 1'b1);
      chk(34'({lz, rz}), 34'(2'b00));
      burst(1, 1'b1);
      chk(34'({lz, rz}), 34'(2'b11));
    end
    rd(STATUS_OFS, {RESP_OKAY, 32'h0000_0030});
    burst(1, 1'b0);
    chk(34'({lz, rz}), 34'(2'b00));
    wr(SILENCE_OFS, 32'h0000_0000, RESP_OKAY);
    burst(3200, 1'b1);
    chk(34'({lz, rz}), 34'(2'b00));
    repeat (3) @(posedge aclk);
    stop_test();
  end
endmodule : mixer_ctl_tb

// ==== test/sample_src.sv ====
// Sample source model standing in for the playback data path feeding the block.
// Assumes it shares aclk and strobes one sample pair per cycle while run is high.
`timescale 1ns/100ps
module sample_src
(
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic        zero,
  output      logic        sample_valid,
  output      logic [23:0] left_sample,
  output      logic [23:0] right_sample
);
  // ==========================================================================
  // Pattern source.
  // ==========================================================================
  logic [23:0] pat_r = 24'h00_0001; // Moves every cycle so idle lines never look steady.

  // Free-running pattern, so a stale sample can never pass for a fresh one.
  always @(posedge aclk)
  begin
    pat_r <= pat_r + 24'h00_0003;
  end

  // Bit 0 is forced high so a live non-silent sample is never digitally zero.
  assign sample_valid = run;
  assign left_sample  = (run && zero) ? 24'h00_0000 : (pat_r | 24'h00_0001);
  assign right_sample = (run && zero) ? 24'h00_0000 : (~pat_r | 24'h00_0001);
endmodule : sample_src

// ==== verilog/mixer_ctl.sv ====
// Control settings bank of a stereo codec mixer path, with AXI4-Lite access.
// Assumes samples arrive from logic on aclk, qualified by sample_valid.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps

module mixer_ctl
  import mixer_ctl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  input  wire logic        sample_valid,
  input  wire logic [23:0] left_sample,
  input  wire logic [23:0] right_sample,
  output      logic [7:0]  converter_atten_qdb,
  output      logic        converter_blend_mute,
  output      logic [7:0]  serial_atten_qdb,
  output      logic        serial_blend_mute,
  output      logic        mix_active,
  output      logic        main_mute_out,
  output      logic        converter_mute_out,
  output      logic        serial_mute_out,
  output      logic [2:0]  deemph_sel,
  output      logic [7:0]  hpf_corner_hz,
  output      logic        bias_on,
  output      logic        left_converter_on,
  output      logic        right_converter_on,
  output      logic [4:0]  left_gain_db,
  output      logic [4:0]  right_gain_db,
  output      logic        left_zero_flag,
  output      logic        right_zero_flag
);

  // ==========================================================================
  // State.
  // ==========================================================================
  typedef struct packed {
    logic              aw_held;   // Write address taken, waiting for data.
    logic [7:0]        aw_addr;   // Held write address.
    logic              w_held;    // Write data taken, waiting for address.
    logic [31:0]       w_data;    // Held write data.
    logic [3:0]        w_strb;    // Held byte enables.
    logic              bvalid;    // Write response pending.
    logic [1:0]        bresp;     // Write response code.
    logic              rvalid;    // Read data pending.
    logic [31:0]       rdata;     // Read data.
    logic [1:0]        rresp;     // Read response code.
    logic [31:0]       sil_cfg;   // Silence configuration word.
    logic [31:0]       conv_vol;  // Converter blend gain word.
    logic [31:0]       ser_vol;   // Serial blend gain word.
    logic [31:0]       mix_ctl;   // Mute, mixer, de-emphasis and filter word.
    logic [31:0]       adc_ctl;   // Input gain and power word.
    logic [2:0]        deemph_eff;// De-emphasis setting in use.
    logic [3:0]        lgain_eff; // Left gain code in use.
    logic [3:0]        rgain_eff; // Right gain code in use.
    logic [1:0][14:0]  zcnt;      // Consecutive zero samples per channel.
    logic [1:0]        zflag;     // Zero flags, bit 0 left, bit 1 right.
  } state_t;

  state_t s_r;   // Registered state.
  state_t s_nxt; // Next state.

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Merges a bus write into a word, one byte lane per strobe bit.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Blend gain code to {mute, attenuation in quarter dB}. The upper end is
  // coarse, so it is a table rather than an offset.
  function automatic logic [8:0] vol_decode(input logic [7:0] c);
    logic [8:0] res;
    res = 9'h000;
    if (c >= VOL_MUTE_CODE)
    begin
      res = {1'b1, 8'h00};
    end
    else if (c >= 8'hC8)
    begin
      res = {1'b0, 8'hF0};
    end
    else if (c >= 8'hC4)
    begin
      res = {1'b0, 8'hD8};
    end
    else if (c >= 8'hC0)
    begin
      res = {1'b0, 8'hCC};
    end
    else if (c >= 8'hBC)
    begin
      res = {1'b0, 8'hC0};
    end
    else if (c >= 8'hB8)
    begin
      res = {1'b0, 8'hB8};
    end
    else if (c >= 8'h04)
    begin
      res = {1'b0, 8'(c - 8'h04)};
    end
    return res;
  endfunction : vol_decode

  logic [14:0] sil_window;     // Selected window length in samples.
  logic [1:0]  win_sel;        // Window select code.
  logic [23:0] samp [2];       // Sample per channel.
  logic [8:0]  conv_dec;       // Converter gain decode.
  logic [8:0]  ser_dec;        // Serial gain decode.
  logic [31:0] status_word;    // Read-only status view.
  logic        wr_go;          // Address and data both held: perform write.

  assign samp[0] = left_sample;
  assign samp[1] = right_sample;
  assign win_sel = {s_r.sil_cfg[SIL_SEL_HI], s_r.sil_cfg[SIL_SEL_LO]};
  assign wr_go = s_r.aw_held && s_r.w_held && !s_r.bvalid;

  // Window select decode.
  always_comb
  begin
    case (win_sel)
      2'h0: sil_window = WIN_3200;
      2'h1: sil_window = WIN_4800;
      2'h2: sil_window = WIN_9600;
      default: sil_window = WIN_19600;
    endcase
  end

  // ==========================================================================
  // Next-state logic: bus slave, settings and silence counters.
  // ==========================================================================
  always_comb
  begin
    s_nxt = s_r;
    // Address and data are taken independently, in either order.
    if (awvalid && awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
    end
    if (s_r.bvalid && bready)
    begin
      s_nxt.bvalid = 1'b0;
    end
    // Perform the write once both halves are present.
    if (wr_go)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      if (s_r.aw_addr == SILENCE_OFS)
      begin
        s_nxt.sil_cfg = merge(s_r.sil_cfg, s_r.w_data, s_r.w_strb) & 32'h0000_0007;
      end
      else if (s_r.aw_addr == CONV_VOL_OFS)
      begin
        s_nxt.conv_vol = merge(s_r.conv_vol, s_r.w_data, s_r.w_strb) & 32'h0000_00FF;
      end
      else if (s_r.aw_addr == SER_VOL_OFS)
      begin
        s_nxt.ser_vol = merge(s_r.ser_vol, s_r.w_data, s_r.w_strb) & 32'h0000_00FF;
      end
      else if (s_r.aw_addr == MIX_CTL_OFS)
      begin
        s_nxt.mix_ctl = merge(s_r.mix_ctl, s_r.w_data, s_r.w_strb) & 32'h0000_01FF;
        // A reserved de-emphasis code leaves the de-emphasis in use as it was.
        if (s_nxt.mix_ctl[DEEMPH_LO +: 3] <= DEEMPH_MAX_CODE)
        begin
          s_nxt.deemph_eff = s_nxt.mix_ctl[DEEMPH_LO +: 3];
        end
      end
      else if (s_r.aw_addr == ADC_CTL_OFS)
      begin
        s_nxt.adc_ctl = merge(s_r.adc_ctl, s_r.w_data, s_r.w_strb) & 32'h0000_07FF;
        // Each channel's gain is checked and kept on its own.
        if (s_nxt.adc_ctl[LGAIN_LO +: 4] <= GAIN_MAX_CODE)
        begin
          s_nxt.lgain_eff = s_nxt.adc_ctl[LGAIN_LO +: 4];
        end
        if (s_nxt.adc_ctl[RGAIN_LO +: 4] <= GAIN_MAX_CODE)
        begin
          s_nxt.rgain_eff = s_nxt.adc_ctl[RGAIN_LO +: 4];
        end
      end
      else if (s_r.aw_addr == STATUS_OFS)
      begin
        s_nxt.bresp = RESP_OKAY;
      end
      else
      begin
        s_nxt.bresp = RESP_SLVERR;
      end
    end
    // Reads answer one edge after the address is taken.
    if (s_r.rvalid && rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      if (araddr == SILENCE_OFS)
      begin
        s_nxt.rdata = s_r.sil_cfg;
      end
      else if (araddr == CONV_VOL_OFS)
      begin
        s_nxt.rdata = s_r.conv_vol;
      end
      else if (araddr == SER_VOL_OFS)
      begin
        s_nxt.rdata = s_r.ser_vol;
      end
      else if (araddr == MIX_CTL_OFS)
      begin
        s_nxt.rdata = s_r.mix_ctl;
      end
      else if (araddr == ADC_CTL_OFS)
      begin
        s_nxt.rdata = s_r.adc_ctl;
      end
      else if (araddr == STATUS_OFS)
      begin
        s_nxt.rdata = status_word;
      end
      else
      begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = RESP_SLVERR;
      end
    end
    // Silence watch: counts saturate at the window, so a long silence cannot wrap.
    for (int ch = 0; ch < 2; ch++)
    begin
      if (!s_r.sil_cfg[SIL_EN_BIT])
      begin
        s_nxt.zcnt[ch] = 15'h0000;
        s_nxt.zflag[ch] = 1'b0;
      end
      else if (sample_valid)
      begin
        if (samp[ch] == 24'h00_0000)
        begin
          if (s_r.zcnt[ch] < sil_window)
          begin
            s_nxt.zcnt[ch] = s_r.zcnt[ch] + 15'h0001;
          end
          else
          begin
            // A window shortened mid-count pulls the count back to its end.
            s_nxt.zcnt[ch] = sil_window;
          end
          s_nxt.zflag[ch] = (s_nxt.zcnt[ch] >= sil_window);
        end
        else
        begin
          s_nxt.zcnt[ch] = 15'h0000;
          s_nxt.zflag[ch] = 1'b0;
        end
      end
    end
  end

  // Registers the whole state; a reset clears every setting.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs.
  // ==========================================================================
  // The bus accepts one write and one read at a time.
  assign awready = !s_r.aw_held && !s_r.bvalid;
  assign wready = !s_r.w_held && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;

  assign conv_dec = vol_decode(s_r.conv_vol[7:0]);
  assign ser_dec = vol_decode(s_r.ser_vol[7:0]);
  assign converter_atten_qdb = conv_dec[7:0];
  assign converter_blend_mute = conv_dec[8];
  assign serial_atten_qdb = ser_dec[7:0];
  assign serial_blend_mute = ser_dec[8];

  // Path mutes are meaningless outside mixer mode, so they are gated here.
  assign mix_active = s_r.mix_ctl[MIX_EN_BIT];
  assign main_mute_out = s_r.mix_ctl[MAIN_MUTE_BIT];
  assign converter_mute_out = mix_active && s_r.mix_ctl[CONV_MUTE_BIT];
  assign serial_mute_out = mix_active && s_r.mix_ctl[SER_MUTE_BIT];
  assign deemph_sel = s_r.deemph_eff;

  // Corners scale with sample rate; the figures hold at 44.1 kHz only.
  always_comb
  begin
    case (s_r.mix_ctl[HPF_LO +: 2])
      2'h0: hpf_corner_hz = 8'h00;
      2'h1: hpf_corner_hz = HPF_3HZ;
      2'h2: hpf_corner_hz = HPF_100HZ;
      default: hpf_corner_hz = HPF_200HZ;
    endcase
  end

  assign bias_on = s_r.adc_ctl[BIAS_BIT];
  assign left_converter_on = bias_on && s_r.adc_ctl[LPWR_BIT];
  assign right_converter_on = bias_on && s_r.adc_ctl[RPWR_BIT];
  assign left_gain_db = 5'(s_r.lgain_eff * 3);
  assign right_gain_db = 5'(s_r.rgain_eff * 3);
  assign left_zero_flag = s_r.zflag[0];
  assign right_zero_flag = s_r.zflag[1];

  // Status flags are all active high.
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_SER_BIT] = serial_mute_out;
    status_word[ST_CONV_BIT] = converter_mute_out;
    status_word[ST_MAIN_BIT] = main_mute_out;
    status_word[ST_LZERO_BIT] = s_r.zflag[0];
    status_word[ST_RZERO_BIT] = s_r.zflag[1];
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence write_ready_s;
    s_r.aw_held && s_r.w_held && !s_r.bvalid;
  endsequence
  sequence read_taken_s;
    arvalid && arready;
  endsequence

  a_write_answer: assert property (write_ready_s |=> bvalid)
    else $error("Write response missing after address and data.");
  a_read_answer: assert property (read_taken_s
      |=> rvalid ##0 (rresp == RESP_OKAY || rdata == 32'h0000_0000))
    else $error("Read answer missing.");
  a_status_ro: assert property (write_ready_s ##0 (s_r.aw_addr == STATUS_OFS)
      |=> $stable(s_r.mix_ctl) && $stable(s_r.adc_ctl) && $stable(s_r.sil_cfg))
    else $error("Status write changed a setting.");
  a_watch_off: assert property (!s_r.sil_cfg[SIL_EN_BIT] |=> !left_zero_flag && !right_zero_flag)
    else $error("Zero flag raised while watch disabled.");
  a_nonzero_clears: assert property (s_r.sil_cfg[SIL_EN_BIT] && sample_valid
      && left_sample != 24'h00_0000 |=> !left_zero_flag)
    else $error("Left zero flag kept after a nonzero sample.");
  a_flag_window: assert property ($rose(left_zero_flag) |-> s_r.zcnt[0] == $past(sil_window))
    else $error("Zero flag raised before the window filled.");
  a_vol_table: assert property ((s_r.conv_vol[7:0] == 8'hC0 |-> converter_atten_qdb == 8'd204)
      and (s_r.conv_vol[7:0] >= 8'hCC |-> converter_blend_mute))
    else $error("Converter gain decode wrong.");
  a_mix_gate: assert property (!mix_active |-> !converter_mute_out && !serial_mute_out)
    else $error("Path mute acted outside mixer mode.");
  a_bias_gate: assert property (!bias_on |-> !left_converter_on && !right_converter_on)
    else $error("Converter powered with bias off.");
  a_gain_hold: assert property (write_ready_s ##0 (s_r.aw_addr == ADC_CTL_OFS)
      && s_r.w_strb[0] && s_r.w_data[7:4] > GAIN_MAX_CODE |=> $stable(s_r.lgain_eff))
    else $error("Reserved gain code was applied.");

endmodule : mixer_ctl

// ==== verilog/mixer_ctl_pkg.sv ====
// Constants shared by the mixer control settings block.
// Assumes a 40 MHz aclk and an AXI4-Lite master with 32-bit data.
package mixer_ctl_pkg;

  // ==========================================================================
  // Register byte offsets.
  // ==========================================================================
  localparam logic [7:0] SILENCE_OFS = 8'h00;  // Silence window and enable.
  localparam logic [7:0] CONV_VOL_OFS = 8'h04; // Converter blend gain code.
  localparam logic [7:0] SER_VOL_OFS = 8'h08;  // Serial blend gain code.
  localparam logic [7:0] MIX_CTL_OFS = 8'h0C;  // Mutes, mixer, de-emphasis, filter.
  localparam logic [7:0] ADC_CTL_OFS = 8'h10;  // Input gains and power bits.
  localparam logic [7:0] STATUS_OFS = 8'h14;   // Read-only flags.

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int SIL_EN_BIT = 0;    // Silence watch enable.
  localparam int SIL_SEL_LO = 1;    // Window select, low bit.
  localparam int SIL_SEL_HI = 2;    // Window select, high bit.
  localparam int DEEMPH_LO = 0;     // De-emphasis select, bits 2:0.
  localparam int HPF_LO = 3;        // Filter corner select, bits 4:3.
  localparam int MIX_EN_BIT = 5;    // Mixer enable.
  localparam int MAIN_MUTE_BIT = 6; // Master mute.
  localparam int CONV_MUTE_BIT = 7; // Converter path mute.
  localparam int SER_MUTE_BIT = 8;  // Serial path mute.
  localparam int RGAIN_LO = 0;      // Right input gain, bits 3:0.
  localparam int LGAIN_LO = 4;      // Left input gain, bits 7:4.
  localparam int LPWR_BIT = 8;      // Left converter power.
  localparam int RPWR_BIT = 9;      // Right converter power.
  localparam int BIAS_BIT = 10;     // Bias power.
  localparam int ST_SER_BIT = 0;    // Serial path mute in effect.
  localparam int ST_CONV_BIT = 1;   // Converter path mute in effect.
  localparam int ST_MAIN_BIT = 2;   // Master mute in effect.
  localparam int ST_LZERO_BIT = 4;  // Left output is zero.
  localparam int ST_RZERO_BIT = 5;  // Right output is zero.

  // ==========================================================================
  // Reset values, code limits and decode figures.
  // ==========================================================================
  localparam logic [31:0] CFG_RESET = 32'h0000_0000; // Every setting clears.
  localparam logic [3:0] GAIN_MAX_CODE = 4'h8;       // Highest legal gain code.
  localparam logic [2:0] DEEMPH_MAX_CODE = 3'h4;     // Highest legal de-emphasis.
  localparam logic [7:0] VOL_MUTE_CODE = 8'hCC;      // First full-mute code.
  localparam logic [14:0] WIN_3200 = 15'h0C80;       // Silence windows in samples.
  localparam logic [14:0] WIN_4800 = 15'h12C0;
  localparam logic [14:0] WIN_9600 = 15'h2580;
  localparam logic [14:0] WIN_19600 = 15'h4C90;
  localparam logic [7:0] HPF_3HZ = 8'h03;            // Corners at 44.1 kHz.
  localparam logic [7:0] HPF_100HZ = 8'h64;
  localparam logic [7:0] HPF_200HZ = 8'hC8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mixer_ctl_pkg
